// File: sms_pkg.sv
// Constants for the serial peripheral port: register indices, fields, resets, timing
package sms_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] SMS_IDX_CTRL    = 8'hBC;
	localparam logic [7:0] SMS_IDX_STAT    = 8'hBD;
	localparam logic [7:0] SMS_IDX_DATA    = 8'hBE;
	localparam logic [7:0] SMS_IDX_IEN     = 8'hA9;
	localparam logic [7:0] SMS_IDX_PRIO_LO = 8'hBA;
	localparam logic [7:0] SMS_IDX_PRIO_HI = 8'hBB;

	// Control register fields
	localparam int SMS_CTL_ENABLE = 7;
	localparam int SMS_CTL_MASTER = 6;
	localparam int SMS_CTL_CLOCK_IDLE_LEVEL   = 5;
	localparam int SMS_CTL_SAMPLE_EDGE_SELECT   = 4;
	localparam int SMS_CTL_SELECT_PIN_DISABLE  = 3;
	localparam int SMS_CTL_BIT_ORDER_SELECT   = 2;
	localparam int SMS_CTL_RATE   = 0;

	// Status register fields
	localparam int SMS_ST_DONE = 7;
	localparam int SMS_ST_WRITE_COLLISION_FLAG = 6;
	localparam int SMS_ST_MODE_FAULT_FLAG = 5;
	localparam int SMS_ST_OVF  = 4;
	localparam int SMS_ST_FULL = 3;
	localparam int SMS_ST_BUSY = 2;

	// Interrupt enable and priority bit positions in their registers
	localparam int SMS_IEN_BIT  = 4;
	localparam int SMS_PRIO_BIT = 4;

	// Reset values
	localparam logic [7:0] SMS_CTRL_RST = 8'h00;
	localparam logic [7:0] SMS_DATA_RST = 8'h00;

	// Bit periods: sixteen clock edges per byte
	localparam logic [3:0] SMS_LAST_EDGE = 4'hF;

	// Half serial period minus one, in system clocks, per rate code
	localparam logic [2:0] SMS_HALF_RELOAD [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

	typedef enum logic {
		SMS_IDLE = 1'b0,
		SMS_XFER = 1'b1
	} sms_state_e;

endpackage : sms_pkg

// File: sms_spi_port.sv
// Serial peripheral port: APB register slave, master and slave shift engine
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) Unit works only while the enable bit is set.
// (R2) Role bit: zero selects slave, one selects master.
// (R3) Serial clock idles at the level of the polarity bit.
// (R4) Phase zero samples on first clock edge, phase one on second.
// (R5) Select pin honoured unless the select-disable bit is set.
// (R6) Bit order: zero sends MSB first, one sends LSB first.
// (R7) Master clock is system clock over 2, 4, 8 or 16 by rate code.
// (R8) Done flag sets at the end of every transfer.
// (R9) Done flag clears on interrupt vectoring or on writing zero.
// (R10) Data write while busy sets the collision flag.
// (R11) Collision flag clears on writing zero or on a non-busy data write.
// (R12) Master with select in use: low select sets mode fault; zero clears.
// (R13) Mode fault clears the enable and master bits.
// (R14) Buffer-full flag sets at transfer end; zero write or data read clears.
// (R15) Transfer end with buffer full sets overrun; zero write or data read clears.
// (R16) Busy flag reads one while a transfer runs.
// (R17) Data write loads shift register; in master role it starts a transfer.
// (R18) Data read returns the receive buffer, separate from the transmit path.
// (R19) Interrupt priority is two bits from two separate priority registers.
// (R20) Interrupt request passes only while its enable bit is set.
// (R21) As slave, the outside master clocks and holds select low per byte.
module sms_spi_port
	import sms_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt to processor
	input  wire logic        irq_vector_ack,
	output logic             irq_request,
	output logic      [1:0]  irq_priority,
	// Serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	// Master-out pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	// Master-in pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	// Slave select pin
	input  wire logic        ss_n_in
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]  ctrl;
	logic        ien;
	logic        prio_lo;
	logic        prio_hi;
	logic        done_flag;
	logic        write_collision_flag_flag;
	logic        mode_fault_flag_flag;
	logic        ovf_flag;
	logic        full_flag;
	logic [7:0]  rx_buf;
	logic [7:0]  tx_sh;
	logic [7:0]  rx_sh;
	sms_state_e  state;
	logic [2:0]  div_cnt;
	logic [3:0]  edge_cnt;
	logic [3:0]  pin_meta;
	logic [3:0]  pin_sync;
	logic        sck_prev;

	logic [7:0]  next_ctrl;
	logic        next_ien;
	logic        next_prio_lo;
	logic        next_prio_hi;
	logic        next_done_flag;
	logic        next_write_collision_flag_flag;
	logic        next_mode_fault_flag_flag;
	logic        next_ovf_flag;
	logic        next_full_flag;
	logic [7:0]  next_rx_buf;
	logic [7:0]  next_tx_sh;
	logic [7:0]  next_rx_sh;
	sms_state_e  next_state;
	logic [2:0]  next_div_cnt;
	logic [3:0]  next_edge_cnt;
	logic        next_sck_out;
	logic        next_sck_oe;
	logic        next_mosi_out;
	logic        next_mosi_oe;
	logic        next_miso_out;
	logic        next_miso_oe;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        next_irq_request;
	logic [1:0]  next_irq_priority;

	////////////////////////////////////////////////////////////////////////////
	// Decoded control and bus terms

	logic        en;
	logic        mst;
	logic        clock_idle_level;
	logic        sample_edge_select;
	logic        select_pin_disable;
	logic        bit_order_select;
	logic [1:0]  rate;
	logic        sck_s;
	logic        mosi_s;
	logic        miso_s;
	logic        ss_s;
	logic        acc_first;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic        addr_ok;
	logic        mapped;
	logic        ctl_wr;
	logic        st_wr;
	logic        dat_wr;
	logic        dat_rd;
	logic        sel;
	logic        tick;
	logic        lead_ev;
	logic        trail_ev;
	logic        sample_ev;
	logic        change_ev;
	logic        last_ev;
	logic        busy;
	logic        rx_bit;
	logic        mode_fault_flag_set;
	logic [7:0]  stat_rd;
	logic [7:0]  rd_byte;

	assign en     = ctrl[SMS_CTL_ENABLE];
	assign mst    = ctrl[SMS_CTL_MASTER];
	assign clock_idle_level   = ctrl[SMS_CTL_CLOCK_IDLE_LEVEL];
	assign sample_edge_select   = ctrl[SMS_CTL_SAMPLE_EDGE_SELECT];
	assign select_pin_disable  = ctrl[SMS_CTL_SELECT_PIN_DISABLE];
	assign bit_order_select   = ctrl[SMS_CTL_BIT_ORDER_SELECT];
	assign rate   = ctrl[SMS_CTL_RATE +: 2];

	// Pin order in the synchroniser: sck, mosi, miso, select
	assign sck_s  = pin_sync[0];
	assign mosi_s = pin_sync[1];
	assign miso_s = pin_sync[2];
	assign ss_s   = pin_sync[3];

	// Answer one cycle into the access phase; the write lands with pready
	assign acc_first = psel & penable & ~pready;
	assign wr        = psel & penable & pready & pwrite;
	assign rd        = psel & penable & pready & ~pwrite;
	assign idx       = paddr[9:2];
	assign addr_ok   = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
	assign mapped    = addr_ok & ((idx == SMS_IDX_CTRL) | (idx == SMS_IDX_STAT)
	                 | (idx == SMS_IDX_DATA) | (idx == SMS_IDX_IEN)
	                 | (idx == SMS_IDX_PRIO_LO) | (idx == SMS_IDX_PRIO_HI));
	assign ctl_wr    = wr & addr_ok & (idx == SMS_IDX_CTRL);
	assign st_wr     = wr & addr_ok & (idx == SMS_IDX_STAT);
	assign dat_wr    = wr & addr_ok & (idx == SMS_IDX_DATA);
	assign dat_rd    = rd & addr_ok & (idx == SMS_IDX_DATA);

	////////////////////////////////////////////////////////////////////////////
	// Shift engine events

	// Slave selected by pin, or always when the pin is ignored
	assign sel  = select_pin_disable | ~ss_s; // R5
	assign tick = (state == SMS_XFER) & (div_cnt == 3'h0);

	always_comb begin
		if (mst) begin
			lead_ev  = en & tick & ~edge_cnt[0];
			trail_ev = en & tick & edge_cnt[0];
		end else begin
			// Edges of the outside clock, relative to its idle level
			lead_ev  = en & sel & (sck_prev == clock_idle_level) & (sck_s != clock_idle_level); // R21 R3
			trail_ev = en & sel & (sck_prev != clock_idle_level) & (sck_s == clock_idle_level); // R21 R3
		end
	end

	assign sample_ev = sample_edge_select ? trail_ev : lead_ev; // R4
	assign change_ev = sample_edge_select ? (lead_ev & (edge_cnt != 4'h0)) : trail_ev; // R4
	assign last_ev   = trail_ev & (edge_cnt == SMS_LAST_EDGE);
	assign busy      = mst ? (state == SMS_XFER) : (edge_cnt != 4'h0); // R16
	assign rx_bit    = mst ? miso_s : mosi_s;
	assign mode_fault_flag_set  = en & mst & ~select_pin_disable & ~ss_s; // R12

	assign stat_rd = {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovf_flag, full_flag, busy, 2'h0};

	always_comb begin
		unique case (idx)
			SMS_IDX_CTRL:    rd_byte = ctrl;
			SMS_IDX_STAT:    rd_byte = stat_rd;
			SMS_IDX_DATA:    rd_byte = rx_buf; // R18
			SMS_IDX_IEN:     rd_byte = {3'h0, ien, 4'h0};
			SMS_IDX_PRIO_LO: rd_byte = {3'h0, prio_lo, 4'h0};
			SMS_IDX_PRIO_HI: rd_byte = {3'h0, prio_hi, 4'h0};
			default:         rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		// Bus answer
		next_pready  = acc_first;
		next_pslverr = acc_first & ~mapped;
		next_prdata  = 32'h0000_0000;
		if (acc_first & ~pwrite & mapped) begin
			next_prdata = {24'h00_0000, rd_byte};
		end

		// Control and interrupt setup
		next_ctrl    = ctrl;
		next_ien     = ien;
		next_prio_lo = prio_lo;
		next_prio_hi = prio_hi;
		if (ctl_wr) begin
			next_ctrl = pwdata[7:0];
		end
		if (wr & addr_ok & (idx == SMS_IDX_IEN)) begin
			next_ien = pwdata[SMS_IEN_BIT];
		end
		if (wr & addr_ok & (idx == SMS_IDX_PRIO_LO)) begin
			next_prio_lo = pwdata[SMS_PRIO_BIT];
		end
		if (wr & addr_ok & (idx == SMS_IDX_PRIO_HI)) begin
			next_prio_hi = pwdata[SMS_PRIO_BIT];
		end
		// Fault overrides a control write in the same cycle
		if (mode_fault_flag_set) begin
			next_ctrl[SMS_CTL_ENABLE] = 1'b0; // R13
			next_ctrl[SMS_CTL_MASTER] = 1'b0; // R13
		end

		// Flags: a hardware set always beats a clear in the same cycle
		next_done_flag = done_flag;
		if ((st_wr & ~pwdata[SMS_ST_DONE]) | irq_vector_ack) begin
			next_done_flag = 1'b0; // R9
		end
		if (last_ev) begin
			next_done_flag = 1'b1; // R8
		end

		next_write_collision_flag_flag = write_collision_flag_flag;
		if ((st_wr & ~pwdata[SMS_ST_WRITE_COLLISION_FLAG]) | (dat_wr & ~busy)) begin
			next_write_collision_flag_flag = 1'b0; // R11
		end
		if (dat_wr & busy) begin
			next_write_collision_flag_flag = 1'b1; // R10
		end

		next_mode_fault_flag_flag = mode_fault_flag_flag;
		if (st_wr & ~pwdata[SMS_ST_MODE_FAULT_FLAG]) begin
			next_mode_fault_flag_flag = 1'b0; // R12
		end
		if (mode_fault_flag_set) begin
			next_mode_fault_flag_flag = 1'b1; // R12
		end

		next_ovf_flag = ovf_flag;
		if ((st_wr & ~pwdata[SMS_ST_OVF]) | dat_rd) begin
			next_ovf_flag = 1'b0; // R15
		end
		if (last_ev & full_flag) begin
			next_ovf_flag = 1'b1; // R15
		end

		next_full_flag = full_flag;
		if ((st_wr & ~pwdata[SMS_ST_FULL]) | dat_rd) begin
			next_full_flag = 1'b0; // R14
		end
		if (last_ev) begin
			next_full_flag = 1'b1; // R14
		end

		// Receive shift and buffer
		next_rx_sh = rx_sh;
		if (sample_ev) begin
			next_rx_sh = bit_order_select ? {rx_bit, rx_sh[7:1]} : {rx_sh[6:0], rx_bit}; // R6
		end
		next_rx_buf = rx_buf;
		if (last_ev) begin
			next_rx_buf = next_rx_sh; // R18
		end

		// Transmit shift; a write during a transfer is dropped
		next_tx_sh = tx_sh;
		if (dat_wr & ~busy) begin
			next_tx_sh = pwdata[7:0]; // R17
		end else if (change_ev) begin
			next_tx_sh = bit_order_select ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0}; // R6
		end

		// Bit-edge counter and master clock generator
		next_state    = state;
		next_div_cnt  = div_cnt;
		next_edge_cnt = edge_cnt;
		next_sck_out  = sck_out;
		if (lead_ev | trail_ev) begin
			next_edge_cnt = edge_cnt + 4'h1;
		end
		unique case (state)
			SMS_IDLE: begin
				next_sck_out = clock_idle_level; // R3
				if (en & mst & dat_wr) begin
					next_state    = SMS_XFER; // R17
					next_div_cnt  = SMS_HALF_RELOAD[rate]; // R7
					next_edge_cnt = 4'h0;
				end
			end
			SMS_XFER: begin
				if (tick) begin
					next_div_cnt = SMS_HALF_RELOAD[rate]; // R7
					next_sck_out = ~sck_out;
					if (last_ev) begin
						next_state = SMS_IDLE;
					end
				end else begin
					next_div_cnt = div_cnt - 3'h1;
				end
			end
		endcase
		// Slave byte framing restarts whenever select is released
		if (~en | (~mst & ~sel)) begin
			next_edge_cnt = 4'h0; // R1 R21
		end
		if (~en | ~mst) begin
			next_state   = SMS_IDLE; // R1 R2
			next_sck_out = clock_idle_level; // R3
		end

		// Pin drivers
		next_sck_oe   = en & mst; // R1 R2
		next_mosi_oe  = en & mst; // R2
		next_miso_oe  = en & ~mst & sel; // R2 R5
		next_mosi_out = bit_order_select ? next_tx_sh[0] : next_tx_sh[7]; // R6
		next_miso_out = next_mosi_out;

		// Interrupt request
		next_irq_request  = next_done_flag & ien; // R20
		next_irq_priority = {prio_hi, prio_lo}; // R19
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl         <= SMS_CTRL_RST;
			ien          <= 1'b0;
			prio_lo      <= 1'b0;
			prio_hi      <= 1'b0;
			done_flag    <= 1'b0;
			write_collision_flag_flag    <= 1'b0;
			mode_fault_flag_flag    <= 1'b0;
			ovf_flag     <= 1'b0;
			full_flag    <= 1'b0;
			rx_buf       <= SMS_DATA_RST;
			tx_sh        <= SMS_DATA_RST;
			rx_sh        <= SMS_DATA_RST;
			state        <= SMS_IDLE;
			div_cnt      <= 3'h0;
			edge_cnt     <= 4'h0;
			pin_meta     <= 4'h8;
			pin_sync     <= 4'h8;
			sck_prev     <= 1'b0;
			sck_out      <= 1'b0;
			sck_oe       <= 1'b0;
			mosi_out     <= 1'b0;
			mosi_oe      <= 1'b0;
			miso_out     <= 1'b0;
			miso_oe      <= 1'b0;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			irq_request  <= 1'b0;
			irq_priority <= 2'h0;
		end else begin
			ctrl         <= next_ctrl;
			ien          <= next_ien;
			prio_lo      <= next_prio_lo;
			prio_hi      <= next_prio_hi;
			done_flag    <= next_done_flag;
			write_collision_flag_flag    <= next_write_collision_flag_flag;
			mode_fault_flag_flag    <= next_mode_fault_flag_flag;
			ovf_flag     <= next_ovf_flag;
			full_flag    <= next_full_flag;
			rx_buf       <= next_rx_buf;
			tx_sh        <= next_tx_sh;
			rx_sh        <= next_rx_sh;
			state        <= next_state;
			div_cnt      <= next_div_cnt;
			edge_cnt     <= next_edge_cnt;
			// Pins are asynchronous: two stages before any logic
			pin_meta     <= {ss_n_in, miso_in, mosi_in, sck_in};
			pin_sync     <= pin_meta;
			sck_prev     <= sck_s;
			sck_out      <= next_sck_out;
			sck_oe       <= next_sck_oe;
			mosi_out     <= next_mosi_out;
			mosi_oe      <= next_mosi_oe;
			miso_out     <= next_miso_out;
			miso_oe      <= next_miso_oe;
			prdata       <= next_prdata;
			pready       <= next_pready;
			pslverr      <= next_pslverr;
			irq_request  <= next_irq_request;
			irq_priority <= next_irq_priority;
		end
	end

endmodule : sms_spi_port

// File: sms_spi_port_sva.sv
// Assertion checker for the serial peripheral port
`timescale 1ns/1ps
module sms_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt
	input wire logic        irq_vector_ack,
	input wire logic        irq_request,
	input wire logic [1:0]  irq_priority,
	// Pins
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        mosi_oe,
	input wire logic        miso_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [4:0] gap;
	logic       ps;
	////////////////////////////////////////
	// Cycles since the clock pin last moved, saturating
	always_ff @(posedge clk) begin
		ps <= sck_out;
		gap <= (rst || sck_out != ps) ? 5'h01 : ((gap == 5'h1F) ? gap : gap + 5'h01);
	end
	////////////////////////////////////////
	property p_ans; $rose(penable) && psel |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("access not answered");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_rd0; !pready |-> prdata == 32'h0 && !pslverr; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside answer");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_oex; !(sck_oe && miso_oe); endproperty
	a_oex: assert property (p_oex) else $error("master and slave drive");
	property p_oem; sck_oe == mosi_oe; endproperty
	a_oem: assert property (p_oem) else $error("master pins disagree");
	property p_ack; irq_vector_ack |=> ##1 !irq_request; endproperty
	a_ack: assert property (p_ack) else $error("vector did not clear");
	property p_pri; $changed(irq_priority) |-> $past(pready && pwrite) || $past(pready && pwrite, 2); endproperty
	a_pri: assert property (p_pri) else $error("priority moved alone");
	property p_rate; sck_oe && $past(sck_oe) && sck_out != ps |-> gap inside {1, 2, 4, 8} || gap > 5'h08; endproperty
	a_rate: assert property (p_rate) else $error("bad clock half period");
	c_irq: cover property ($rose(irq_request));
	c_err: cover property (pslverr);
	c_slv: cover property ($rose(miso_oe));
endmodule : sms_chk

// File: sms_peer.sv
// Behavioural outside slave for master-mode transfers
`timescale 1ns/1ps
module sms_peer (
	// Pins
	input wire logic       sck,
	input wire logic       mosi,
	output logic           miso,
	// Frame setup
	input wire logic       act,
	input wire logic       clock_idle_level,
	input wire logic       sample_edge_select,
	input wire logic       bit_order_select,
	input wire logic [7:0] tx,
	output logic     [7:0] rx
);
	int k;
	initial miso = 1'h0;
	// Out of frame the line shows the inverse, never a stale bit
	always @(act) begin
		k = 0;
		miso = (act && !sample_edge_select) ? tx[bit_order_select ? 0 : 7] : ~miso;
	end
	always @(sck) begin
		if (act && ((sck ^ clock_idle_level) != sample_edge_select)) begin
			rx = bit_order_select ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		end else if (act) begin
			k = k + !sample_edge_select;
			miso = (k > 7) ? ~miso : tx[bit_order_select ? k : 7 - k];
			k = k + sample_edge_select;
		end
	end
endmodule : sms_peer

// File: spi_master_slave_port_bench.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`define CK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module spi_master_slave_port_bench;
	import sms_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ack = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, irq, sck_o, sck_e, mo_o, mo_e, mi_o, mi_e, ev, pmiso;
	logic        ss_n = 1, bsck = 0, bmosi = 0, act = 0;
	logic [1:0]  prio;
	logic [7:0]  ptx = '0, prx, rv, ctl = '0;
	int          bad_count = 0, tests_run = 0;
	wire         sck = sck_e ? sck_o : bsck;
	wire         mosi = mo_e ? mo_o : bmosi;
	wire         miso = mi_e ? mi_o : pmiso;
	always #20 clk = ~clk;
	sms_spi_port i_dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_vector_ack(ack), .irq_request(irq), .irq_priority(prio),
		.sck_in(sck), .sck_out(sck_o), .sck_oe(sck_e), .mosi_in(mosi), .mosi_out(mo_o),
		.mosi_oe(mo_e), .miso_in(miso), .miso_out(mi_o), .miso_oe(mi_e), .ss_n_in(ss_n));
	sms_peer i_peer (
		.sck(sck), .mosi(mosi), .miso(pmiso), .act(act), .clock_idle_level(ctl[5]), .sample_edge_select(ctl[4]),
		.bit_order_select(ctl[2]), .tx(ptx), .rx(prx));
	////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
		int k;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, ix, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wait_done();
		int k;
		k = 0;
		do begin
			apb(1'h0, SMS_IDX_STAT, 8'h00);
			k++;
		end while (rv[SMS_ST_DONE] !== 1'h1 && k < 60);
	endtask : wait_done
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////
	task automatic t_reset();
		apb(1'h0, SMS_IDX_CTRL, 8'h00);
		`CK("ctrl", SMS_CTRL_RST, rv)
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("stat", 8'h00, rv)
		apb(1'h0, SMS_IDX_DATA, 8'h00);
		`CK("data", SMS_DATA_RST, rv)
		apb(1'h0, 8'h10, 8'h00);
		`CK("unmapped", 1'h1, ev)
	endtask : t_reset
	task automatic t_off();
		apb(1'h1, SMS_IDX_CTRL, 8'h40);
		apb(1'h1, SMS_IDX_DATA, 8'h55);
		repeat (40) @(posedge clk);
		`CK("clock pin driven", 1'h0, sck_e)
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("idle status", 8'h00, rv)
	endtask : t_off
	task automatic t_modes();
		for (int i = 0; i < 8; i++) begin
			ctl = {2'h3, i[2:1], 1'h0, i[0], 2'h2};
			apb(1'h1, SMS_IDX_CTRL, ctl);
			apb(1'h1, SMS_IDX_IEN, {3'h0, i[0], 4'h0});
			ptx = 8'h3C ^ i[7:0];
			act = 1'h1;
			apb(1'h1, SMS_IDX_DATA, 8'hA1 + i[7:0]);
			wait_done();
			act = 1'h0;
			`CK("done status", 8'h88, rv)
			`CK("peer rx", 8'hA1 + i[7:0], prx)
			`CK("clock idle", ctl[5], sck)
			`CK("irq", i[0], irq)
			@(posedge clk) ack <= 1'h1;
			@(posedge clk) ack <= 1'h0;
			apb(1'h0, SMS_IDX_DATA, 8'h00);
			`CK("data", ptx, rv)
			apb(1'h0, SMS_IDX_STAT, 8'h00);
			`CK("cleared", 8'h00, rv)
		end
	endtask : t_modes
	task automatic t_rate();
		int n;
		for (int r = 0; r < 4; r++) begin
			apb(1'h1, SMS_IDX_CTRL, {6'h30, r[1:0]});
			apb(1'h1, SMS_IDX_DATA, 8'h00);
			n = 0;
			while (sck !== 1'h1 && n < 40) begin
				@(posedge clk);
				n++;
			end
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (sck === 1'h1 && n < 40);
			`CK("half period", 1 << r, n)
			wait_done();
			// Clear every flag so the next rate waits for its own transfer
			apb(1'h1, SMS_IDX_STAT, 8'h00);
		end
	endtask : t_rate
	task automatic t_busy();
		apb(1'h1, SMS_IDX_STAT, 8'h00);
		apb(1'h0, SMS_IDX_DATA, 8'h00);
		apb(1'h1, SMS_IDX_CTRL, 8'hC2);
		ctl = 8'hC2;
		act = 1'h1;
		apb(1'h1, SMS_IDX_DATA, 8'h5A);
		apb(1'h1, SMS_IDX_DATA, 8'hFF);
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("busy collision", 8'h44, rv)
		wait_done();
		`CK("dropped write", 8'h5A, prx)
		// Clear only done, so the next wait sees the second transfer
		apb(1'h1, SMS_IDX_STAT, 8'h78);
		apb(1'h1, SMS_IDX_DATA, 8'h96);
		wait_done();
		act = 1'h0;
		`CK("overrun", 8'h98, rv)
		apb(1'h0, SMS_IDX_DATA, 8'h00);
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("read clears", 8'h80, rv)
		apb(1'h1, SMS_IDX_STAT, 8'h00);
	endtask : t_busy
	task automatic t_fault();
		apb(1'h1, SMS_IDX_CTRL, 8'hC0);
		ss_n <= 1'h0;
		repeat (6) @(posedge clk);
		apb(1'h0, SMS_IDX_CTRL, 8'h00);
		`CK("fault ctrl", 8'h00, rv)
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("fault flag", 1'h1, rv[SMS_ST_MODE_FAULT_FLAG])
		apb(1'h1, SMS_IDX_CTRL, 8'hC8);
		repeat (6) @(posedge clk);
		apb(1'h0, SMS_IDX_CTRL, 8'h00);
		`CK("select ignored", 8'hC8, rv)
		apb(1'h1, SMS_IDX_STAT, 8'h00);
		apb(1'h0, SMS_IDX_STAT, 8'h00);
		`CK("fault cleared", 1'h0, rv[SMS_ST_MODE_FAULT_FLAG])
		ss_n <= 1'h1;
	endtask : t_fault
	task automatic t_slave();
		logic [7:0] got;
		logic [7:0] m;
		m = 8'hA5;
		apb(1'h1, SMS_IDX_CTRL, 8'h80);
		apb(1'h1, SMS_IDX_DATA, 8'h3C);
		ss_n <= 1'h0;
		for (int b = 7; b >= 0; b--) begin
			bmosi <= m[b];
			repeat (8) @(posedge clk);
			bsck <= 1'h1;
			got[b] = miso;
			repeat (8) @(posedge clk);
			bsck <= 1'h0;
		end
		repeat (8) @(posedge clk);
		ss_n <= 1'h1;
		`CK("slave out", 8'h3C, got)
		wait_done();
		`CK("slave status", 8'h88, rv)
		apb(1'h0, SMS_IDX_DATA, 8'h00);
		`CK("slave in", 8'hA5, rv)
	endtask : t_slave
	task automatic t_prio();
		for (int p = 0; p < 4; p++) begin
			apb(1'h1, SMS_IDX_PRIO_LO, {3'h0, p[0], 4'h0});
			apb(1'h1, SMS_IDX_PRIO_HI, {3'h0, p[1], 4'h0});
			repeat (2) @(posedge clk);
			`CK("priority", p[1:0], prio)
		end
	endtask : t_prio
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_off();
		t_modes();
		t_rate();
		t_busy();
		t_fault();
		t_slave();
		t_prio();
		print_verdict();
	end
	// Whole run needs some fifteen hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
endmodule : spi_master_slave_port_bench
bind sms_spi_port sms_chk i_chk (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_vector_ack(irq_vector_ack),
	.irq_request(irq_request), .irq_priority(irq_priority), .sck_out(sck_out),
	.sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));
